// ---- logic/arfp_record_path.sv ----
// Record path: polarity, high-pass, notch, digital gain and level-control peak detector.
// Assumes samples and register accesses arrive on clk_sys from logic in the same domain.
// What this block does
// - Carry 24-bit samples through every stage.
// - Samples are signed two's complement.
// - Path runs only with converter enable set.
// - Polarity bit negates every sample, saturating at full scale.
// - Oversampling select picks 64 or 128.
// - High-pass applied only when enabled.
// - Audio mode: first-order, about 3.7 Hz.
// - Application mode: second-order, coded cut-off.
// - Cut-off 82 to 408 Hz, scaled by rate.
// - Rate group taken from sample rate code.
// - Notch inserted only when enabled.
// - Two 14-bit coefficients, split high/low.
// - Update bit transfers coefficients to filter.
// - Gain zero mutes; else half-dB attenuation.
// - Level control watches decimator output directly.
// - Peak loads larger magnitude.
// - Peak decays toward zero otherwise.
// - Compare peak with target, adjust amplifier.
// - Level control drives amplifier gain field.
// - Level control runs only when enabled.
// - Disabled level control keeps last gain.
// - Lower above target, raise 1.5 dB below.
module arfp_record_path (
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    input  wire logic                   regWrite,
    input  wire logic [6:0]             regAddr,
    input  wire logic [8:0]             regWdata,
    output logic      [8:0]             regRdata,
    input  wire arfp_pkg::arfp_sample_s sampleIn,
    output arfp_pkg::arfp_sample_s      sampleOut,
    output logic                        osrSelect128,
    output logic      [5:0]             inputAmpGain
);
    timeunit 1ns;
    timeprecision 1ns;

    arfp_pkg::arfp_state_s cur;
    arfp_pkg::arfp_state_s nxt;

    localparam logic signed [47:0] POS_MAX = 48'sh0000007FFFFF;
    localparam logic signed [47:0] NEG_MIN = -48'sh000000800000;

    function automatic logic signed [23:0] sat24(input logic signed [47:0] v);
        logic signed [23:0] r;
        if (v > POS_MAX) begin
            r = 24'sh7FFFFF;
        end else if (v < NEG_MIN) begin
            r = -24'sh800000;
        end else begin
            r = v[23:0];
        end
        return r;
    endfunction

    // One-pole high-pass: y = s - alpha*s, s = y1 + x - x1
    function automatic logic signed [23:0] hpPole(input logic signed [23:0] x,
                                                  input logic signed [23:0] x1,
                                                  input logic signed [23:0] y1,
                                                  input logic [15:0]        alpha);
        logic signed [47:0] s;
        logic signed [47:0] a;
        s = 48'(y1) + 48'(x) - 48'(x1);
        a = 48'(signed'({1'b0, alpha}));
        return sat24(s - ((s * a) >>> 16));
    endfunction

    logic signed [23:0] xPol;
    logic signed [23:0] hpA;
    logic signed [23:0] hpOut;
    logic signed [23:0] apOut;
    logic signed [23:0] notchOut;
    logic signed [23:0] gainOut;
    logic signed [47:0] c0;
    logic signed [47:0] c1;
    logic signed [47:0] acc;
    logic [15:0]        alpha;
    logic [1:0]         rateShift;
    logic [7:0]         steps;
    logic [7:0]         shiftAmt;
    logic [7:0]         frac;
    logic [22:0]        mag;
    logic [15:0]        target;
    logic [15:0]        lower;
    logic [31:0]        lowerProd;
    logic [15:0]        peakTop;
    logic               notchWrite;

    always_comb begin
        nxt        = cur;
        xPol       = '0;
        hpA        = '0;
        hpOut      = '0;
        apOut      = '0;
        notchOut   = '0;
        gainOut    = '0;
        c0         = 48'(cur.coefA);
        c1         = 48'(cur.coefB);
        acc        = '0;
        alpha      = '0;
        rateShift  = '0;
        steps      = '0;
        shiftAmt   = '0;
        frac       = '0;
        mag        = '0;
        target     = '0;
        lower      = '0;
        lowerProd  = '0;
        peakTop    = '0;
        notchWrite = 1'b0;
        nxt.out.valid = 1'b0;

        if (regWrite) begin
            case (regAddr)
                arfp_pkg::OFF_POWER:  nxt.regPower  = regWdata;
                arfp_pkg::OFF_RATE:   nxt.regRate   = regWdata;
                arfp_pkg::OFF_FILT:   nxt.regFilt   = regWdata;
                arfp_pkg::OFF_GAIN:   nxt.regGain   = {1'b0, regWdata[7:0]};
                arfp_pkg::OFF_ALC:    nxt.regAlc    = regWdata;
                arfp_pkg::OFF_TARGET: nxt.regTarget = regWdata;
                arfp_pkg::OFF_AMP:    nxt.regAmp    = regWdata;
                arfp_pkg::OFF_NA_HI: begin
                    nxt.regNaHi = {1'b0, regWdata[7:0]};
                    notchWrite  = 1'b1;
                end
                arfp_pkg::OFF_NA_LO: begin
                    nxt.regNaLo = {2'b00, regWdata[6:0]};
                    notchWrite  = 1'b1;
                end
                arfp_pkg::OFF_NB_HI: begin
                    nxt.regNbHi = {2'b00, regWdata[6:0]};
                    notchWrite  = 1'b1;
                end
                arfp_pkg::OFF_NB_LO: begin
                    nxt.regNbLo = {2'b00, regWdata[6:0]};
                    notchWrite  = 1'b1;
                end
                default: ;
            endcase
        end
        // Staged parts, including this write, move in one step
        if (notchWrite && regWdata[arfp_pkg::BIT_UPDATE]) begin
            nxt.coefA = {nxt.regNaHi[6:0], nxt.regNaLo[6:0]};
            nxt.coefB = {nxt.regNbHi[6:0], nxt.regNbLo[6:0]};
        end

        if (sampleIn.valid) begin
            // Converter off: drop the sample and restart every stage from zero
            if (!cur.regPower[arfp_pkg::BIT_CONV_EN]) begin
                nxt.hx1a = '0;
                nxt.hy1a = '0;
                nxt.hx1b = '0;
                nxt.hy1b = '0;
                nxt.nx1  = '0;
                nxt.nx2  = '0;
                nxt.ny1  = '0;
                nxt.ny2  = '0;
                nxt.peak = '0;
            end else begin
                // Negated full scale would wrap, so it saturates instead
                if (cur.regFilt[arfp_pkg::BIT_POL]) begin
                    xPol = sat24(-48'(sampleIn.data));
                end else begin
                    xPol = sampleIn.data;
                end

                // Lowest rate group keeps table values; each higher group halves the ratio
                case (cur.regRate[arfp_pkg::RATE_LSB+2 -: 2])
                    2'h1:    rateShift = 2'h1;
                    2'h0:    rateShift = 2'h2;
                    default: rateShift = 2'h0;
                endcase
                if (cur.regFilt[arfp_pkg::BIT_HP_MODE]) begin
                    alpha = arfp_pkg::HP_ALPHA[cur.regFilt[arfp_pkg::HP_CODE_LSB+:3]] >> rateShift;
                end else begin
                    alpha = arfp_pkg::HP_AUDIO_ALPHA;
                end
                hpA = hpPole(xPol, cur.hx1a, cur.hy1a, alpha);
                if (cur.regFilt[arfp_pkg::BIT_HP_MODE]) begin
                    hpOut = hpPole(hpA, cur.hx1b, cur.hy1b, alpha);
                end else begin
                    hpOut = hpA;
                end
                if (cur.regFilt[arfp_pkg::BIT_HP_EN]) begin
                    nxt.hx1a = xPol;
                    nxt.hy1a = hpA;
                    nxt.hx1b = hpA;
                    nxt.hy1b = hpOut;
                end else begin
                    hpOut = xPol;
                end

                // Allpass: A0 = -c0/2^13, A1 = -c1/2^12; notch = (x + allpass)/2
                acc = -((c0 * 48'(hpOut)) >>> 13) - ((c1 * 48'(cur.nx1)) >>> 12) + 48'(cur.nx2)
                      + ((c1 * 48'(cur.ny1)) >>> 12) + ((c0 * 48'(cur.ny2)) >>> 13);
                apOut = sat24(acc);
                if (cur.regNaHi[arfp_pkg::BIT_NOTCH_EN]) begin
                    notchOut = sat24((48'(hpOut) + 48'(apOut)) >>> 1);
                    nxt.nx1  = hpOut;
                    nxt.nx2  = cur.nx1;
                    nxt.ny1  = apOut;
                    nxt.ny2  = cur.ny1;
                end else begin
                    notchOut = hpOut;
                end

                // Attenuation: mantissa per half-dB step, plain shift per 6 dB
                if (cur.regGain[7:0] == 8'h00) begin
                    gainOut = '0;
                end else begin
                    steps    = arfp_pkg::GAIN_FULL_CODE - cur.regGain[7:0];
                    shiftAmt = steps / arfp_pkg::GAIN_STEPS_PER_SHIFT;
                    frac     = steps % arfp_pkg::GAIN_STEPS_PER_SHIFT;
                    acc      = (48'(notchOut) * 48'(signed'({1'b0, arfp_pkg::GAIN_MANT[frac[3:0]]}))) >>> 15;
                    gainOut  = sat24(acc >>> shiftAmt);
                end
                nxt.out.valid = 1'b1;
                nxt.out.data  = gainOut;

                // Peak detector on the raw decimator word
                if (sampleIn.data[23]) begin
                    mag = (sampleIn.data == -24'sh800000) ? 23'h7FFFFF : 23'(-sampleIn.data);
                end else begin
                    mag = sampleIn.data[22:0];
                end
                if (mag > cur.peak) begin
                    nxt.peak = mag;
                end else begin
                    nxt.peak = cur.peak - (cur.peak >> arfp_pkg::PEAK_DECAY_SHIFT);
                end

                // A level-control step lands on top of a same-cycle gain write
                if (cur.alcCount == arfp_pkg::ALC_UPDATE_SAMPLES - 8'h01) begin
                    nxt.alcCount = '0;
                    target    = arfp_pkg::TARGET_TAB[cur.regTarget[3:0]];
                    lowerProd = 32'(target) * 32'(arfp_pkg::LOWER_FACTOR);
                    lower     = lowerProd[30:15];
                    peakTop   = cur.peak[22:7];
                    // Disabled control leaves the gain field to software
                    if (cur.regAlc[arfp_pkg::BIT_ALC_EN]) begin
                        if (peakTop > target) begin
                            if (nxt.regAmp[5:0] != 6'h00) begin
                                nxt.regAmp[5:0] = nxt.regAmp[5:0] - 6'h01;
                            end
                        end else if (peakTop < lower) begin
                            if (nxt.regAmp[5:0] != arfp_pkg::AMP_GAIN_MAX) begin
                                nxt.regAmp[5:0] = nxt.regAmp[5:0] + 6'h01;
                            end
                        end
                    end
                end else begin
                    nxt.alcCount = cur.alcCount + 8'h01;
                end
            end
        end

        nxt.osr128  = nxt.regFilt[arfp_pkg::BIT_OSR];
        nxt.ampGain = nxt.regAmp[5:0];

        // Read data lags the address by one edge and shows pre-write contents
        case (regAddr)
            arfp_pkg::OFF_POWER:  nxt.rdata = cur.regPower;
            arfp_pkg::OFF_RATE:   nxt.rdata = cur.regRate;
            arfp_pkg::OFF_FILT:   nxt.rdata = cur.regFilt;
            arfp_pkg::OFF_GAIN:   nxt.rdata = cur.regGain;
            arfp_pkg::OFF_NA_HI:  nxt.rdata = cur.regNaHi;
            arfp_pkg::OFF_NA_LO:  nxt.rdata = cur.regNaLo;
            arfp_pkg::OFF_NB_HI:  nxt.rdata = cur.regNbHi;
            arfp_pkg::OFF_NB_LO:  nxt.rdata = cur.regNbLo;
            arfp_pkg::OFF_ALC:    nxt.rdata = cur.regAlc;
            arfp_pkg::OFF_TARGET: nxt.rdata = cur.regTarget;
            arfp_pkg::OFF_AMP:    nxt.rdata = cur.regAmp;
            default:              nxt.rdata = 9'h000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cur           <= '0;
            cur.regGain   <= arfp_pkg::RST_GAIN;
            cur.regAmp    <= arfp_pkg::RST_AMP;
            cur.regAlc    <= arfp_pkg::RST_ALC;
            cur.regTarget <= arfp_pkg::RST_TARGET;
            cur.ampGain   <= arfp_pkg::RST_AMP[5:0];
        end else begin
            cur <= nxt;
        end
    end

    // Every output comes straight from the state register
    assign regRdata     = cur.rdata;
    assign sampleOut    = cur.out;
    assign osrSelect128 = cur.osr128;
    assign inputAmpGain = cur.ampGain;
endmodule // arfp_record_path

// ---- include/arfp_pkg.sv ----
// Constants, tables and carrier types of the record filter path.
// Assumes a single system clock and a register port on that clock.
package arfp_pkg;
    localparam int SAMPLE_W = 24;
    localparam int ADDR_W   = 7;
    localparam int DATA_W   = 9;

    localparam logic [6:0] OFF_POWER  = 7'h02;
    localparam logic [6:0] OFF_RATE   = 7'h07;
    localparam logic [6:0] OFF_FILT   = 7'h0E;
    localparam logic [6:0] OFF_GAIN   = 7'h0F;
    localparam logic [6:0] OFF_NA_HI  = 7'h1B;
    localparam logic [6:0] OFF_NA_LO  = 7'h1C;
    localparam logic [6:0] OFF_NB_HI  = 7'h1D;
    localparam logic [6:0] OFF_NB_LO  = 7'h1E;
    localparam logic [6:0] OFF_ALC    = 7'h20;
    localparam logic [6:0] OFF_TARGET = 7'h21;
    localparam logic [6:0] OFF_AMP    = 7'h2D;

    localparam int BIT_CONV_EN  = 0;
    localparam int BIT_POL      = 0;
    localparam int BIT_OSR      = 3;
    localparam int BIT_HP_EN    = 8;
    localparam int BIT_HP_MODE  = 7;
    localparam int HP_CODE_LSB  = 4;
    localparam int RATE_LSB     = 1;
    localparam int BIT_NOTCH_EN = 7;
    localparam int BIT_UPDATE   = 8;
    localparam int BIT_ALC_EN   = 8;

    localparam logic [8:0] RST_ZERO   = 9'h000;
    localparam logic [8:0] RST_GAIN   = 9'h0FF;
    localparam logic [8:0] RST_AMP    = 9'h010;
    localparam logic [8:0] RST_ALC    = 9'h038;
    localparam logic [8:0] RST_TARGET = 9'h000;

    // One-pole coefficients, scaled by 2^16
    localparam logic [15:0] HP_AUDIO_ALPHA = 16'h0020;
    localparam logic [7:0][15:0] HP_ALPHA = {16'h520C, 16'h41C2, 16'h347C, 16'h2906,
                                             16'h20C7, 16'h1A58, 16'h1483, 16'h107D};
    // Half-dB attenuation mantissas, scaled by 2^15
    localparam logic [11:0][15:0] GAIN_MANT = {16'h43F4, 16'h47FB, 16'h4C3F, 16'h50C3,
                                               16'h558C, 16'h5A9E, 16'h5FFD, 16'h65AD,
                                               16'h6BB3, 16'h7215, 16'h78D7, 16'h8000};
    localparam logic [7:0]  GAIN_STEPS_PER_SHIFT = 8'h0C;
    localparam logic [7:0]  GAIN_FULL_CODE       = 8'hFF;
    // Peak thresholds on the top 16 magnitude bits, -34.5 dB to -12 dB
    localparam logic [15:0][15:0] TARGET_TAB = {16'h4027, 16'h35FA, 16'h2D6B, 16'h2637,
                                                16'h2027, 16'h1B0E, 16'h1627, 16'h1327,
                                                16'h101D, 16'h0D8F, 16'h0B69, 16'h0999,
                                                16'h0814, 16'h06CC, 16'h05B8, 16'h04D0};
    localparam logic [15:0] LOWER_FACTOR     = 16'h6BB3;
    localparam int          PEAK_DECAY_SHIFT = 8;
    localparam logic [7:0]  ALC_UPDATE_SAMPLES = 8'h10;
    localparam logic [5:0]  AMP_GAIN_MAX     = 6'h3F;

    typedef struct packed {
        logic                        valid;
        logic signed [SAMPLE_W-1:0]  data;
    } arfp_sample_s;

    typedef struct packed {
        logic [8:0]         regPower;
        logic [8:0]         regRate;
        logic [8:0]         regFilt;
        logic [8:0]         regGain;
        logic [8:0]         regNaHi;
        logic [8:0]         regNaLo;
        logic [8:0]         regNbHi;
        logic [8:0]         regNbLo;
        logic [8:0]         regAlc;
        logic [8:0]         regTarget;
        logic [8:0]         regAmp;
        logic signed [13:0] coefA;
        logic signed [13:0] coefB;
        logic signed [23:0] hx1a;
        logic signed [23:0] hy1a;
        logic signed [23:0] hx1b;
        logic signed [23:0] hy1b;
        logic signed [23:0] nx1;
        logic signed [23:0] nx2;
        logic signed [23:0] ny1;
        logic signed [23:0] ny2;
        logic [22:0]        peak;
        logic [7:0]         alcCount;
        logic [8:0]         rdata;
        arfp_sample_s       out;
        logic               osr128;
        logic [5:0]         ampGain;
    } arfp_state_s;
endpackage : arfp_pkg

// ---- verif/arfp_record_path_checker.sv ----
// Port-level checker of the record path.
// Assumes it is bound to arfp_record_path and registers are only written through its port.
module arfp_record_path_checker (
    input wire logic                   clk_sys,
    input wire logic                   rstn,
    input wire logic                   regWrite,
    input wire logic [6:0]             regAddr,
    input wire logic [8:0]             regWdata,
    input wire logic [8:0]             regRdata,
    input wire arfp_pkg::arfp_sample_s sampleIn,
    input wire arfp_pkg::arfp_sample_s sampleOut,
    input wire logic                   osrSelect128,
    input wire logic [5:0]             inputAmpGain
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] filtReg;
    logic [7:0] gainReg;
    logic       convEn;
    logic       notchEn;
    logic       level_ctrl_enable;
    logic       alcEnD;
    wire        takeIn  = sampleIn.valid && convEn;
    wire        passCfg = !filtReg[8] && !notchEn && gainReg == 8'hFF;
    wire        ampWr   = regWrite && regAddr == arfp_pkg::OFF_AMP;

    // Shadow copies of the control bits
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            filtReg <= 9'h000;
            gainReg <= 8'hFF;
            convEn  <= 1'b0;
            notchEn <= 1'b0;
            level_ctrl_enable   <= 1'b0;
            alcEnD  <= 1'b0;
        end else begin
            alcEnD <= level_ctrl_enable;
            if (regWrite && regAddr == arfp_pkg::OFF_POWER) convEn <= regWdata[0];
            if (regWrite && regAddr == arfp_pkg::OFF_FILT) filtReg <= regWdata;
            if (regWrite && regAddr == arfp_pkg::OFF_GAIN) gainReg <= regWdata[7:0];
            if (regWrite && regAddr == arfp_pkg::OFF_NA_HI) notchEn <= regWdata[7];
            if (regWrite && regAddr == arfp_pkg::OFF_ALC) level_ctrl_enable <= regWdata[8];
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    AST_OUT_AFTER_IN: assert property (takeIn |=> sampleOut.valid)
        else $error("missing output sample");
    AST_NO_OUT_WHEN_OFF: assert property (sampleOut.valid |-> $past(takeIn))
        else $error("output without accepted sample");
    AST_OSR_FOLLOWS: assert property (regWrite && regAddr == arfp_pkg::OFF_FILT |=> osrSelect128 == $past(regWdata[3]))
        else $error("oversampling select wrong");
    AST_PASS_THROUGH: assert property (takeIn && passCfg && !filtReg[0] |=> sampleOut.data == $past(sampleIn.data))
        else $error("pass-through sample changed");
    AST_INVERT: assert property (takeIn && passCfg && filtReg[0] && sampleIn.data != 24'h800000
        |=> sampleOut.data == -$past(sampleIn.data))
        else $error("inverted sample wrong");
    AST_MUTE: assert property (takeIn && gainReg == 8'h00 |=> sampleOut.data == 24'h000000)
        else $error("muted output not zero");
    AST_AMP_HOLD: assert property (!level_ctrl_enable && !alcEnD && !ampWr |=> $stable(inputAmpGain))
        else $error("amp gain moved while level control off");
    AST_AMP_WRITE: assert property (ampWr && !level_ctrl_enable && !alcEnD |=> inputAmpGain == $past(regWdata[5:0]))
        else $error("amp gain write not applied");
    AST_ALC_STEP: assert property (level_ctrl_enable && !ampWr |=> $stable(inputAmpGain)
        || inputAmpGain == $past(inputAmpGain) + 6'h01 || inputAmpGain == $past(inputAmpGain) - 6'h01)
        else $error("amp gain step larger than one");
    AST_UPDATE_NOT_KEPT: assert property (regAddr == arfp_pkg::OFF_NB_LO |=> regRdata[8] == 1'b0)
        else $error("update bit read back");

    COV_INVERT: cover property (takeIn && filtReg[0]);
    COV_MUTE: cover property (takeIn && gainReg == 8'h00);
    COV_ALC_MOVE: cover property (level_ctrl_enable && $changed(inputAmpGain));
endmodule // arfp_record_path_checker

bind arfp_record_path arfp_record_path_checker chk_u (.clk_sys(clk_sys), .rstn(rstn), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .sampleIn(sampleIn), .sampleOut(sampleOut),
    .osrSelect128(osrSelect128), .inputAmpGain(inputAmpGain));

// ---- verif/arfp_modulator_model.sv ----
// Far-side model: modulator and decimator handing over one sample per spacing+1 clocks.
// Assumes the bench changes level, run and spacing on falling edges.
module arfp_modulator_model (
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    input  wire logic               run,
    input  wire logic [3:0]         spacing,
    input  wire logic signed [23:0] level,
    output arfp_pkg::arfp_sample_s  sampleIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] phase;

    always @(negedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            phase = 4'h0;
            sampleIn = '0;
        end else if (run && phase >= spacing) begin
            phase = 4'h0;
            sampleIn.valid = 1'b1;
            sampleIn.data = level;
        end else begin
            phase = run ? phase + 4'h1 : 4'h0;
            sampleIn.valid = 1'b0;
            // Stale data must not look valid between samples
            sampleIn.data = ~sampleIn.data;
        end
    end
endmodule // arfp_modulator_model

// ---- verif/adc_record_filter_path_test.sv ----
// Bench for the record path: registers, sample stream, filters and level control.
// Assumes the checker binds itself from its own file.
module adc_record_filter_path_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   clk_sys = 1'b0;
    logic                   rstn = 1'b0;
    logic                   regWrite = 1'b0;
    logic [6:0]             regAddr = 7'h00;
    logic [8:0]             regWdata = 9'h000;
    logic [8:0]             regRdata;
    arfp_pkg::arfp_sample_s sampleIn;
    arfp_pkg::arfp_sample_s sampleOut;
    logic                   osrSelect128;
    logic [5:0]             inputAmpGain;
    logic                   run = 1'b0;
    logic [3:0]             spacing = 4'h3;
    logic signed [23:0]     level = 24'h000000;
    logic signed [23:0]     d;
    logic [5:0]             g;
    int                     n_mismatch = 0;
    int                     checks_done = 0;

    always #50 clk_sys = ~clk_sys;

    arfp_record_path dut_u (.clk_sys(clk_sys), .rstn(rstn), .regWrite(regWrite), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .sampleIn(sampleIn), .sampleOut(sampleOut),
        .osrSelect128(osrSelect128), .inputAmpGain(inputAmpGain));
    arfp_modulator_model model_u (.clk_sys(clk_sys), .rstn(rstn), .run(run), .spacing(spacing),
        .level(level), .sampleIn(sampleIn));

    task automatic check(input logic ok, input string what);
        checks_done++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [8:0] v);
        @(negedge clk_sys);
        regAddr = a;
        regWdata = v;
        regWrite = 1'b1;
        @(negedge clk_sys);
        regWrite = 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, input logic [8:0] e);
        @(negedge clk_sys);
        regAddr = a;
        @(negedge clk_sys);
        check(regRdata === e, "read value");
    endtask

    // Returns the n-th output sample from now
    task automatic out_n(input int n, output logic signed [23:0] v);
        int i;
        i = 0;
        repeat (n) begin
            do begin
                @(posedge clk_sys);
                #1;
                i++;
            end while (sampleOut.valid !== 1'b1 && i < 2000);
        end
        check(i < 2000, "no output sample");
        v = sampleOut.data;
    endtask

    task automatic t_reset;
        @(negedge clk_sys);
        rstn = 1'b0;
        repeat (4) @(negedge clk_sys);
        rstn = 1'b1;
        check(inputAmpGain === 6'h10 && osrSelect128 === 1'b0, "reset outputs");
        rd(arfp_pkg::OFF_GAIN, 9'h0FF);
        rd(arfp_pkg::OFF_ALC, 9'h038);
        rd(arfp_pkg::OFF_NB_HI, 9'h000);
        rd(7'h3F, 9'h000);
    endtask

    task automatic t_disabled;
        run = 1'b1;
        spacing = 4'h0;
        repeat (20) begin
            @(posedge clk_sys);
            #1;
            check(sampleOut.valid === 1'b0, "output while converter off");
        end
        spacing = 4'h3;
    endtask

    task automatic t_pass;
        level = 24'h123456;
        wr(arfp_pkg::OFF_POWER, 9'h001);
        out_n(2, d);
        check(d === 24'h123456, "pass-through");
        wr(arfp_pkg::OFF_FILT, 9'h009);
        check(osrSelect128 === 1'b1, "osr 128");
        out_n(2, d);
        check(d === 24'hEDCBAA, "inverted");
        level = 24'h800000;
        out_n(2, d);
        check(d === 24'h7FFFFF, "inverted full scale");
        wr(arfp_pkg::OFF_GAIN, 9'h000);
        out_n(2, d);
        check(d === 24'h000000, "mute");
        wr(arfp_pkg::OFF_GAIN, 9'h0FF);
        wr(arfp_pkg::OFF_FILT, 9'h000);
        check(osrSelect128 === 1'b0, "osr 64");
    endtask

    task automatic t_filters;
        level = 24'h400000;
        wr(arfp_pkg::OFF_RATE, 9'h008);
        wr(arfp_pkg::OFF_FILT, 9'h100);
        out_n(2, d);
        check(d < 24'sh400000 && d > 24'sh200000, "audio high-pass");
        wr(arfp_pkg::OFF_FILT, 9'h1F0);
        out_n(40, d);
        check(d < 24'sh100000 && d > -24'sh100000, "second-order high-pass");
        // Converter off clears the filter state; highest rate group quarters alpha
        wr(arfp_pkg::OFF_POWER, 9'h000);
        wr(arfp_pkg::OFF_RATE, 9'h000);
        wr(arfp_pkg::OFF_POWER, 9'h001);
        out_n(1, d);
        check(d === 24'h3627AF, "highest rate group");
        wr(arfp_pkg::OFF_FILT, 9'h000);
        out_n(2, d);
        check(d === 24'h400000, "high-pass bypass");
        wr(arfp_pkg::OFF_NA_HI, 9'h085);
        out_n(2, d);
        check(d === 24'h200000, "notch inserted");
        out_n(2, d);
        check(d === 24'h400000, "notch with staged coefficients");
        wr(arfp_pkg::OFF_NB_LO, 9'h17F);
        rd(arfp_pkg::OFF_NB_LO, 9'h07F);
        rd(arfp_pkg::OFF_NA_HI, 9'h085);
        wr(arfp_pkg::OFF_NA_HI, 9'h000);
    endtask

    task automatic t_level;
        spacing = 4'h0;
        level = 24'h7FFFFF;
        wr(arfp_pkg::OFF_TARGET, 9'h00F);
        wr(arfp_pkg::OFF_ALC, 9'h138);
        repeat (200) @(negedge clk_sys);
        g = inputAmpGain;
        check(g < 6'h10, "gain lowered above target");
        level = 24'h000100;
        repeat (800) @(negedge clk_sys);
        check(inputAmpGain > g, "gain raised below target");
        wr(arfp_pkg::OFF_ALC, 9'h038);
        g = inputAmpGain;
        repeat (100) @(negedge clk_sys);
        check(inputAmpGain === g, "gain held after disable");
        wr(arfp_pkg::OFF_AMP, 9'h020);
        check(inputAmpGain === 6'h20, "software gain");
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        t_reset();
        t_disabled();
        t_pass();
        t_filters();
        t_level();
        t_reset();
        report_and_stop();
    end
endmodule // adc_record_filter_path_test
